/* hlss_consts.svh */
// hlss_consts.svh: offsets, counts and timing for the host-link block
// assumes the system clock runs at 200 MHz
`ifndef HLSS_CONSTS_SVH
`define HLSS_CONSTS_SVH
`define HLSS_CLK_MHZ 200
`define HLSS_T_POR_MS 2
`define HLSS_T_CH_MS 1
`define HLSS_POR_CYC (`HLSS_T_POR_MS * 1000 * `HLSS_CLK_MHZ)
`define HLSS_CH_CYC (`HLSS_T_CH_MS * 1000 * `HLSS_CLK_MHZ)
`define HLSS_UART_BPS 9600
`define HLSS_UART_BIT_CYC ((`HLSS_CLK_MHZ * 1000000 + `HLSS_UART_BPS - 1) / `HLSS_UART_BPS)
`define HLSS_DATA_BITS 8
`define HLSS_STOP_BITS 1
`define HLSS_SPI_MAX_KHZ 4000
`define HLSS_T_CS_NS 1000
`define HLSS_CAL_EDGES 32
`define HLSS_CAL_W 32
`define HLSS_SY_SUP 0
`define HLSS_SY_HRST 1
`define HLSS_SY_PINB 2
`define HLSS_SY_STRAP 3
`define HLSS_SY_WAKE 4
`define HLSS_SY_DRX 5
`define HLSS_SY_RC 6
`define HLSS_SY_RXT 7
`define HLSS_SY_TXT 8
`define HLSS_SY_N 9
`endif

/* hlss_host_model.sv */
// hlss_host_model.sv: host side of the command link and the strap pin
// assumes the bench calls spi_xfer and sets strap_hi
`timescale 1ns/1ps
module hlss_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic strap_out,
  input  wire logic strap_oe,
  input  wire logic strap_pull_dn,
  output logic      strap_in
);
  logic strap_hi = 1'b1;
  logic junk     = 1'b0;
  // idle levels; sclk stands still outside frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // a floating pin wanders
  always #3 junk = ~junk;
  // strap only pulled, never driven by the host
  assign strap_in = strap_oe ? strap_out : strap_hi ? 1'b1 : strap_pull_dn ? 1'b0 : junk;
  // mode 0 frame, msb first, 1000 ns margins
  task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
    #0.7 cs_n = 1'b0;
    #1000;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      #80 sclk = 1'b1;
      rx[i] = strap_in;
      #80 sclk = 1'b0;
    end
    #1000 cs_n = 1'b1;
    mosi = ~mosi;
    #1000;
  endtask
endmodule

/* hlss_pkg.sv */
// hlss_pkg.sv: state types of the host-link block
// assumes nothing beyond a SystemVerilog compiler
package hlss_pkg;
  typedef enum logic [1:0] {HLSS_BOOT_OFF, HLSS_BOOT_POR, HLSS_BOOT_CH, HLSS_BOOT_RUN}
    hlss_boot_type;
  typedef enum logic {HLSS_PWR_HIB, HLSS_PWR_ACT} hlss_pwr_type;
  typedef enum logic [1:0] {HLSS_RX_IDLE, HLSS_RX_START, HLSS_RX_DATA, HLSS_RX_STOP}
    hlss_rx_type;
endpackage

/* hlss_spi_link.sv */
// hlss_spi_link.sv: mode-0 shifter clocked by the host serial clock
// assumes select high between frames; words cross by toggles
`timescale 1ns/1ps
module hlss_spi_link #(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  input  wire logic              sys_rst,
  input  wire logic [DATA_W-1:0] tx_byte,
  output logic                   miso_q,
  output logic [DATA_W-1:0]      rx_byte_q,
  output logic                   rx_tgl_q,
  output logic                   tx_tgl_q
);
  localparam int unsigned CW = $clog2(DATA_W);
  logic [CW-1:0]     bit_q;
  logic [DATA_W-1:0] sh_q;
  logic [DATA_W-1:0] tx_sh_q;

  // sample on rising edge; frame signal clears count
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_q <= '0;
      sh_q  <= '0;
    end
    else
    begin
      bit_q <= bit_q + CW'(1);
      sh_q  <= {sh_q[DATA_W-2:0], mosi};
    end
  end

  // received byte handed over with a toggle
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_byte_q <= '0;
      rx_tgl_q  <= 1'b0;
    end
    else if (!cs_n && bit_q == CW'(DATA_W - 1))
    begin
      rx_byte_q <= {sh_q[DATA_W-2:0], mosi};
      rx_tgl_q  <= ~rx_tgl_q;
    end
  end

  // change data on falling edge; next byte's msb leads
  always_ff @(negedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      miso_q   <= 1'b0;
      tx_sh_q  <= '0;
      tx_tgl_q <= 1'b0;
    end
    else if (bit_q == '0)
    begin
      miso_q   <= tx_byte[DATA_W-1];
      tx_sh_q  <= {tx_byte[DATA_W-2:0], 1'b0};
      tx_tgl_q <= ~tx_tgl_q; // byte taken
    end
    else
    begin
      miso_q  <= tx_sh_q[DATA_W-1];
      tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
    end
  end
endmodule

/* hlss_top.sv */
// hlss_top.sv: strap, command link select, SPI/UART link and sideband pins
// assumes clk 200 MHz crystal-derived; pins resolved from enables outside
`timescale 1ns/1ps
`include "hlss_consts.svh"
module hlss_top #(
  parameter int unsigned POR_CYC   = `HLSS_POR_CYC,
  parameter int unsigned CH_CYC    = `HLSS_CH_CYC,
  parameter int unsigned BIT_CYC   = `HLSS_UART_BIT_CYC,
  parameter int unsigned CAL_EDGES = `HLSS_CAL_EDGES,
  parameter int unsigned DATA_W    = `HLSS_DATA_BITS
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  input  wire logic                   supply_ready,
  input  wire logic                   hard_reset_n,
  output logic                        hard_reset_pull_up,
  input  wire logic                   shared_if_pin_a,
  input  wire logic                   shared_if_pin_b,
  input  wire logic                   shared_if_pin_strap_in,
  output logic                        shared_if_pin_strap_out,
  output logic                        shared_if_pin_strap_oe,
  output logic                        shared_if_pin_strap_pull_dn,
  input  wire logic                   shared_if_pin_d,
  output logic                        event_irq_n,
  input  wire logic                   wake_hold_in,
  output logic                        rf_activity_out,
  input  wire logic                   test_uart_rx,
  output logic                        test_uart_tx_out,
  output logic                        test_uart_tx_oe,
  input  wire logic                   rc_clk_in,
  output logic                        boot_done,
  output logic                        if_mode_spi,
  output logic [DATA_W-1:0]           cmd_rx_data,
  output logic                        cmd_rx_valid,
  input  wire logic [DATA_W-1:0]      cmd_tx_data,
  input  wire logic                   cmd_tx_valid,
  output logic                        cmd_tx_ready,
  input  wire logic                   event_pending,
  input  wire logic                   rf_on,
  input  wire logic                   rf_pol_high,
  input  wire logic                   sleep_req,
  input  wire logic                   wake_req,
  output logic                        power_active,
  input  wire logic                   dtm_enter,
  output logic                        dtm_active,
  input  wire logic                   dtm_tx_bit,
  output logic                        dtm_rx_bit,
  output logic [`HLSS_CAL_W-1:0]      rc_cal
);
  localparam int unsigned BW = $clog2(BIT_CYC + 1);
  localparam int unsigned FRAME = DATA_W + 1 + `HLSS_STOP_BITS;
  localparam int unsigned IW = $clog2(FRAME + 1);

  logic [`HLSS_SY_N-1:0] raw, s1_q, s2_q;
  logic                  dev_rst, spi_miso, spi_rx_tgl, spi_tx_tgl;
  logic [DATA_W-1:0]     spi_rx_byte, spi_tx_q;
  hlss_pkg::hlss_boot_type boot_st_q;
  hlss_pkg::hlss_pwr_type  pwr_st_q;
  hlss_pkg::hlss_rx_type   urx_st_q;
  logic [31:0]           cnt_q;
  logic                  rxt_d_q, txt_d_q, busy_q, rc_d_q;
  logic [BW-1:0]         urx_cnt_q, utx_cnt_q;
  logic [IW-1:0]         urx_bit_q, utx_bit_q;
  logic [DATA_W-1:0]     urx_sh_q;
  logic [DATA_W:0]       utx_sh_q;
  logic                  urx_done_q, utx_busy_q, utx_done_q, uart_tx_q;
  logic [`HLSS_CAL_W-1:0] cal_cyc_q;
  logic [7:0]            cal_edge_q;
  wire  accept = cmd_tx_valid && cmd_tx_ready;
  wire  spi_rx_evt = s2_q[`HLSS_SY_RXT] ^ rxt_d_q;
  wire  spi_tx_evt = s2_q[`HLSS_SY_TXT] ^ txt_d_q;
  wire  rxd = s2_q[`HLSS_SY_PINB];

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // two-flop synchronisers for pins and link toggles
  assign raw = {spi_tx_tgl, spi_rx_tgl, rc_clk_in, test_uart_rx, wake_hold_in,
                shared_if_pin_strap_in, shared_if_pin_b, hard_reset_n, supply_ready};
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // hard reset low holds the device in reset
  assign dev_rst = !s2_q[`HLSS_SY_HRST];

  // weak pull-up kept on the hard reset pin
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hard_reset_pull_up <= 1'b1;
    else if (clk_en)
      hard_reset_pull_up <= 1'b1;
  end

  // boot sequence: supply, power-on reset, strap latch
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_st_q <= hlss_pkg::HLSS_BOOT_OFF;
      cnt_q <= '0;
      boot_done <= 1'b0;
      if_mode_spi <= 1'b0;
      shared_if_pin_strap_pull_dn <= 1'b1;
    end
    else if (clk_en)
    begin
      if (dev_rst || (!s2_q[`HLSS_SY_SUP] && !boot_done))
      begin
        boot_st_q <= hlss_pkg::HLSS_BOOT_OFF;
        cnt_q <= '0;
        boot_done <= 1'b0;
        shared_if_pin_strap_pull_dn <= 1'b1;
      end
      else
        case (boot_st_q)
          hlss_pkg::HLSS_BOOT_OFF:
            boot_st_q <= hlss_pkg::HLSS_BOOT_POR;
          // reset released no earlier than 2 ms
          hlss_pkg::HLSS_BOOT_POR:
            if (cnt_q == POR_CYC - 1)
            begin
              boot_st_q <= hlss_pkg::HLSS_BOOT_CH;
              cnt_q <= '0;
            end
            else
              cnt_q <= cnt_q + 32'h1;
          // strap latched 1 ms after reset release
          hlss_pkg::HLSS_BOOT_CH:
            if (cnt_q == CH_CYC - 1)
            begin
              if_mode_spi <= s2_q[`HLSS_SY_STRAP];
              boot_done <= 1'b1;
              shared_if_pin_strap_pull_dn <= 1'b0;
              boot_st_q <= hlss_pkg::HLSS_BOOT_RUN;
            end
            else
              cnt_q <= cnt_q + 32'h1;
          hlss_pkg::HLSS_BOOT_RUN:
            cnt_q <= '0;
          default:
            boot_st_q <= hlss_pkg::HLSS_BOOT_OFF;
        endcase
    end
  end

  // data out driven in SPI only while selected
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shared_if_pin_strap_oe <= 1'b0;
    else if (clk_en)
      shared_if_pin_strap_oe <= boot_done && !dev_rst && (!if_mode_spi || !rxd);
  end
  // pin a clocks, pin b selects, pin d carries host data
  // strap pin carries UART transmit in UART mode
  assign shared_if_pin_strap_out = if_mode_spi ? spi_miso : uart_tx_q;

  hlss_spi_link #(
    .DATA_W    (DATA_W)
  ) u_link (
    .sclk      (shared_if_pin_a),
    .cs_n      (shared_if_pin_b),
    .mosi      (shared_if_pin_d),
    .sys_rst   (sys_rst),
    .tx_byte   (spi_tx_q),
    .miso_q    (spi_miso),
    .rx_byte_q (spi_rx_byte),
    .rx_tgl_q  (spi_rx_tgl),
    .tx_tgl_q  (spi_tx_tgl)
  );

  // UART receiver, 8 data bits, one stop bit
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      urx_st_q <= hlss_pkg::HLSS_RX_IDLE;
      urx_cnt_q <= '0;
      urx_bit_q <= '0;
      urx_sh_q <= '0;
      urx_done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      urx_done_q <= 1'b0;
      urx_cnt_q <= urx_cnt_q + BW'(1);
      if (dev_rst || !boot_done || if_mode_spi)
        urx_st_q <= hlss_pkg::HLSS_RX_IDLE;
      else
        case (urx_st_q)
          hlss_pkg::HLSS_RX_IDLE:
            if (!rxd)
            begin
              urx_st_q <= hlss_pkg::HLSS_RX_START;
              urx_cnt_q <= '0;
            end
          hlss_pkg::HLSS_RX_START:
            if (urx_cnt_q == BW'(BIT_CYC / 2 - 1))
            begin
              urx_st_q <= rxd ? hlss_pkg::HLSS_RX_IDLE : hlss_pkg::HLSS_RX_DATA;
              urx_cnt_q <= '0;
              urx_bit_q <= '0;
            end
          hlss_pkg::HLSS_RX_DATA:
            if (urx_cnt_q == BW'(BIT_CYC - 1))
            begin
              urx_sh_q <= {rxd, urx_sh_q[DATA_W-1:1]};
              urx_cnt_q <= '0;
              urx_bit_q <= urx_bit_q + IW'(1);
              if (urx_bit_q == IW'(DATA_W - 1))
                urx_st_q <= hlss_pkg::HLSS_RX_STOP;
            end
          hlss_pkg::HLSS_RX_STOP:
            if (urx_cnt_q == BW'(BIT_CYC - 1))
            begin
              urx_done_q <= rxd; // framing error drops the byte
              urx_st_q <= hlss_pkg::HLSS_RX_IDLE;
            end
          default:
            urx_st_q <= hlss_pkg::HLSS_RX_IDLE;
        endcase
    end
  end

  // UART transmitter, start, 8 data lsb first, stop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      uart_tx_q <= 1'b1;
      utx_busy_q <= 1'b0;
      utx_done_q <= 1'b0;
      utx_cnt_q <= '0;
      utx_bit_q <= '0;
      utx_sh_q <= '0;
    end
    else if (clk_en)
    begin
      utx_done_q <= 1'b0;
      if (dev_rst)
      begin
        uart_tx_q <= 1'b1;
        utx_busy_q <= 1'b0;
      end
      else if (!utx_busy_q)
      begin
        if (accept && !if_mode_spi)
        begin
          uart_tx_q <= 1'b0;
          utx_sh_q <= {1'b1, cmd_tx_data};
          utx_busy_q <= 1'b1;
          utx_cnt_q <= '0;
          utx_bit_q <= '0;
        end
      end
      else if (utx_cnt_q != BW'(BIT_CYC - 1))
        utx_cnt_q <= utx_cnt_q + BW'(1);
      else
      begin
        utx_cnt_q <= '0;
        if (utx_bit_q == IW'(FRAME - 1))
        begin
          utx_busy_q <= 1'b0;
          utx_done_q <= 1'b1;
        end
        else
        begin
          uart_tx_q <= utx_sh_q[0];
          utx_sh_q <= {1'b0, utx_sh_q[DATA_W:1]};
          utx_bit_q <= utx_bit_q + IW'(1);
        end
      end
    end
  end

  // received bytes from either link to the command side
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxt_d_q <= 1'b0;
      cmd_rx_valid <= 1'b0;
      cmd_rx_data <= '0;
    end
    else if (clk_en)
    begin
      rxt_d_q <= s2_q[`HLSS_SY_RXT];
      cmd_rx_valid <= 1'b0;
      if (dev_rst || !boot_done)
        cmd_rx_valid <= 1'b0;
      else if (if_mode_spi && spi_rx_evt)
      begin
        cmd_rx_data <= spi_rx_byte;
        cmd_rx_valid <= 1'b1;
      end
      else if (!if_mode_spi && urx_done_q)
      begin
        cmd_rx_data <= urx_sh_q;
        cmd_rx_valid <= 1'b1;
      end
    end
  end

  // transmit handshake: one byte outstanding at a time
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txt_d_q <= 1'b0;
      busy_q <= 1'b0;
      cmd_tx_ready <= 1'b0;
      spi_tx_q <= '0;
    end
    else if (clk_en)
    begin
      txt_d_q <= s2_q[`HLSS_SY_TXT];
      if (dev_rst || !boot_done)
      begin
        busy_q <= 1'b0;
        cmd_tx_ready <= 1'b0;
      end
      else if (accept)
      begin
        busy_q <= 1'b1;
        cmd_tx_ready <= 1'b0;
        if (if_mode_spi)
          spi_tx_q <= cmd_tx_data;
      end
      else if (busy_q)
        busy_q <= if_mode_spi ? !spi_tx_evt : !utx_done_q;
      else
        cmd_tx_ready <= 1'b1;
    end
  end

  // interrupt low while an event is pending
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      event_irq_n <= 1'b1;
    else if (clk_en)
      event_irq_n <= !event_pending;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rf_activity_out <= 1'b0;
    else if (clk_en)
      rf_activity_out <= (rf_on && !dev_rst) ~^ rf_pol_high;
  end

  // test UART stays tri-stated until the command
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dtm_active <= 1'b0;
      test_uart_tx_oe <= 1'b0;
      test_uart_tx_out <= 1'b1;
      dtm_rx_bit <= 1'b1;
    end
    else if (clk_en)
    begin
      dtm_active <= !dev_rst && (dtm_active || dtm_enter);
      test_uart_tx_oe <= dtm_active && !dev_rst;
      test_uart_tx_out <= dtm_active ? dtm_tx_bit : 1'b1;
      dtm_rx_bit <= dtm_active ? s2_q[`HLSS_SY_DRX] : 1'b1;
    end
  end

  // two power states; wake-hold blocks idle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwr_st_q <= hlss_pkg::HLSS_PWR_HIB;
      power_active <= 1'b0;
    end
    else if (clk_en)
    begin
      power_active <= pwr_st_q == hlss_pkg::HLSS_PWR_ACT;
      if (dev_rst || !boot_done)
        pwr_st_q <= hlss_pkg::HLSS_PWR_HIB;
      else
        case (pwr_st_q)
          hlss_pkg::HLSS_PWR_HIB:
            if (wake_req || s2_q[`HLSS_SY_WAKE] || cmd_rx_valid)
              pwr_st_q <= hlss_pkg::HLSS_PWR_ACT;
          hlss_pkg::HLSS_PWR_ACT:
            if (sleep_req && !s2_q[`HLSS_SY_WAKE])
              pwr_st_q <= hlss_pkg::HLSS_PWR_HIB;
          default:
            pwr_st_q <= hlss_pkg::HLSS_PWR_HIB;
        endcase
    end
  end

  // count crystal cycles over RC periods while active
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rc_d_q <= 1'b0;
      cal_cyc_q <= '0;
      cal_edge_q <= '0;
      rc_cal <= '0;
    end
    else if (clk_en)
    begin
      rc_d_q <= s2_q[`HLSS_SY_RC];
      if (dev_rst)
        rc_cal <= '0;
      if (dev_rst || pwr_st_q != hlss_pkg::HLSS_PWR_ACT)
      begin
        cal_cyc_q <= '0;
        cal_edge_q <= '0;
      end
      else if (s2_q[`HLSS_SY_RC] && !rc_d_q)
      begin
        if (cal_edge_q == 8'(CAL_EDGES))
        begin
          rc_cal <= cal_cyc_q + `HLSS_CAL_W'(1);
          cal_cyc_q <= '0;
          cal_edge_q <= 8'h01;
        end
        else
        begin
          cal_cyc_q <= (cal_edge_q == 8'h00) ? '0 : cal_cyc_q + `HLSS_CAL_W'(1);
          cal_edge_q <= cal_edge_q + 8'h01;
        end
      end
      else if (cal_edge_q != 8'h00)
        cal_cyc_q <= cal_cyc_q + `HLSS_CAL_W'(1);
    end
  end

  a_strap_latch_time: assert property ($rose(boot_done) |-> $past(cnt_q) == CH_CYC - 1)
    else $error("strap latched before hold time");
  a_strap_select: assert property ($rose(boot_done) |-> if_mode_spi == $past(s2_q[3]))
    else $error("interface not taken from strap");
  a_miso_hiz_sel: assert property (clk_en && if_mode_spi && rxd |=> !shared_if_pin_strap_oe)
    else $error("data out driven while deselected");
  a_uart_drive: assert property (clk_en && boot_done && !dev_rst && !if_mode_spi
                                 |=> shared_if_pin_strap_oe)
    else $error("UART transmit pin not driven");
  a_uart_stop_bit: assert property (utx_busy_q && utx_bit_q == IW'(FRAME - 1) |-> uart_tx_q)
    else $error("stop bit not high");
  a_irq_follows: assert property (clk_en |=> event_irq_n == !$past(event_pending))
    else $error("interrupt level wrong");
  a_wake_hold_idle: assert property (clk_en && !dev_rst && s2_q[4] &&
                                     pwr_st_q == hlss_pkg::HLSS_PWR_ACT
                                     |=> pwr_st_q == hlss_pkg::HLSS_PWR_ACT)
    else $error("idle entered while wake-hold high");
  a_hard_reset_clear: assert property (clk_en && dev_rst |=> !boot_done && !dtm_active)
    else $error("hard reset did not reset");
  a_test_uart_hiz: assert property (clk_en && !dtm_active |=> !test_uart_tx_oe)
    else $error("test UART driven outside test mode");
  a_rf_polarity: assert property (clk_en && !dev_rst
                                  |=> rf_activity_out == ($past(rf_on) ~^ $past(rf_pol_high)))
    else $error("activity output polarity wrong");
  a_cal_hibernate: assert property (clk_en && !dev_rst && !power_active && !$past(power_active)
                                    |=> $stable(rc_cal))
    else $error("calibration changed in hibernate");
endmodule

/* hlss_top_tb_top.sv */
// hlss_top_tb_top.sv: self-checking bench for the host-link block
// assumes hlss_top and hlss_host_model are compiled first
`timescale 1ns/1ps
`include "hlss_consts.svh"
module hlss_top_tb_top;
  localparam int unsigned BIT = 16;
  logic       clk = 1'b0, sys_rst = 1'b1, supply_ready = 1'b0, hard_reset_n = 1'b1;
  logic       wake_hold_in = 1'b0, test_uart_rx = 1'b1, rc_clk_in = 1'b0, uart_sel = 1'b0;
  logic       uart_line = 1'b1, event_pending = 1'b0, rf_on = 1'b0, rf_pol_high = 1'b1;
  logic       sleep_req = 1'b0, wake_req = 1'b0, dtm_enter = 1'b0, dtm_tx_bit = 1'b1;
  logic       cmd_tx_valid = 1'b0, sclk, cs_n, mosi, pin_b, strap_in, tx_out, tx_oe;
  logic [7:0] cmd_tx_data = 8'h00, cmd_rx_data, rx, b;
  logic       pull_up, strap_out, strap_oe, pull_dn, event_irq_n, rf_activity_out;
  logic       boot_done, if_mode_spi, cmd_rx_valid, cmd_tx_ready, power_active, dtm_rx_bit;
  logic [`HLSS_CAL_W-1:0] rc_cal;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  int         seed = 19542, miscompares = 0, comparisons = 0, cycles = 0;

  hlss_top #(.POR_CYC(40), .CH_CYC(20), .BIT_CYC(BIT), .CAL_EDGES(4), .DATA_W(8)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .supply_ready(supply_ready),
    .hard_reset_n(hard_reset_n), .hard_reset_pull_up(pull_up), .shared_if_pin_a(sclk),
    .shared_if_pin_b(pin_b), .shared_if_pin_strap_in(strap_in),
    .shared_if_pin_strap_out(strap_out), .shared_if_pin_strap_oe(strap_oe),
    .shared_if_pin_strap_pull_dn(pull_dn), .shared_if_pin_d(mosi),
    .event_irq_n(event_irq_n), .wake_hold_in(wake_hold_in),
    .rf_activity_out(rf_activity_out), .test_uart_rx(test_uart_rx),
    .test_uart_tx_out(tx_out), .test_uart_tx_oe(tx_oe), .rc_clk_in(rc_clk_in),
    .boot_done(boot_done), .if_mode_spi(if_mode_spi), .cmd_rx_data(cmd_rx_data),
    .cmd_rx_valid(cmd_rx_valid), .cmd_tx_data(cmd_tx_data), .cmd_tx_valid(cmd_tx_valid),
    .cmd_tx_ready(cmd_tx_ready), .event_pending(event_pending), .rf_on(rf_on),
    .rf_pol_high(rf_pol_high), .sleep_req(sleep_req), .wake_req(wake_req),
    .power_active(power_active), .dtm_enter(dtm_enter), .dtm_active(),
    .dtm_tx_bit(dtm_tx_bit), .dtm_rx_bit(dtm_rx_bit), .rc_cal(rc_cal));
  hlss_host_model u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .strap_out(strap_out),
    .strap_oe(strap_oe), .strap_pull_dn(pull_dn), .strap_in(strap_in));
  // pin b carries select, or the receive line in uart mode
  assign pin_b = uart_sel ? uart_line : cs_n;

  // 200 MHz system clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // slow rc clock, phase unrelated to clk
  initial
  begin
    #1.3;
    forever #250 rc_clk_in = ~rc_clk_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_boot();
    for (int n = 0; n < 90 && boot_done !== 1'b1; n++)
      @(posedge clk);
    chk("boot_done", 1, boot_done);
  endtask

  // hold the request until ready is sampled high
  task automatic send_tx(input logic [7:0] v);
    cmd_tx_data <= v;
    cmd_tx_valid <= 1'b1;
    for (int n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (cmd_tx_ready === 1'b1)
        break;
    end
    cmd_tx_valid <= 1'b0;
  endtask

  // host uart frame: start, 8 bits lsb first, one stop
  task automatic uart_send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      uart_line <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // sample the device uart frame at mid bit
  task automatic uart_take(input logic [7:0] v);
    logic [9:0] f;
    for (int n = 0; n < 40 && strap_in !== 1'b0; n++)
      @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      f[i] = strap_in;
      repeat (BIT) @(posedge clk);
    end
    chk("uart frame", {1'b1, v, 1'b0}, f);
  endtask

  // oldest expected byte against each received byte
  always @(posedge clk)
    if (cmd_rx_valid === 1'b1)
      chk("cmd_rx_data", exp_q.size() ? exp_q.pop_front() : 9'h100, cmd_rx_data);

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    supply_ready <= 1'b1;
    @(posedge clk);
    chk("strap_oe boot", 0, strap_oe);
    chk("tx_oe reset", 0, tx_oe);
    chk("pull_up", 1, pull_up);
    repeat (55) @(posedge clk);
    chk("boot early", 0, boot_done);
    wait_boot();
    chk("if_mode_spi", 1, if_mode_spi);
    chk("strap_oe idle", 0, strap_oe);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      event_pending <= r[0];
      rf_on <= r[1];
      rf_pol_high <= r[2];
      test_uart_rx <= r[3];
      repeat (4) @(posedge clk);
      chk("event_irq_n", !r[0], event_irq_n);
      chk("rf_activity", r[1] == r[2], rf_activity_out);
      chk("dtm_rx_bit off", 1, dtm_rx_bit);
    end
    r = $random(seed);
    b = r[7:0];
    send_tx(b);
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed);
      exp_q.push_back(r[7:0]);
      u_host.spi_xfer(r[7:0], rx);
      if (i == 1) chk("miso byte", b, rx);
      @(posedge clk);
    end
    repeat (10) @(posedge clk);
    chk("spi rx left", 1, exp_q.size() == 0);
    chk("rc_cal", 400, rc_cal);
    wake_hold_in <= 1'b1;
    repeat (4) @(posedge clk);
    sleep_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk("power held", 1, power_active);
    wake_hold_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk("power sleep", 0, power_active);
    sleep_req <= 1'b0;
    dtm_enter <= 1'b1;
    dtm_tx_bit <= 1'b0;
    test_uart_rx <= 1'b0;
    @(posedge clk);
    dtm_enter <= 1'b0;
    repeat (5) @(posedge clk);
    chk("tx_oe test", 1, tx_oe);
    chk("tx_out test", 0, tx_out);
    chk("dtm_rx_bit on", 0, dtm_rx_bit);
    u_host.strap_hi = 1'b0;
    uart_sel <= 1'b1;
    hard_reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    hard_reset_n <= 1'b1;
    wait_boot();
    chk("if_mode_uart", 0, if_mode_spi);
    chk("tx_oe hard", 0, tx_oe);
    repeat (2) @(posedge clk);
    r = $random(seed);
    b = r[7:0];
    exp_q.push_back(b);
    uart_send(b);
    r = $random(seed);
    b = r[7:0];
    send_tx(b);
    uart_take(b);
    repeat (10) @(posedge clk);
    chk("uart rx left", 1, exp_q.size() == 0);
    wrap_up();
  end
endmodule
